/* hw/flash_host.v */
// Host controller for a byte-wide parallel NOR flash.
// Assumes one flash on the pins, inputs synchronous to mclk.
`timescale 1ns/10ps
`include "flash_host_defines.vh"

module flash_host #(
    parameter TIMEOUT_CYC = `TIMEOUT_DEF,
    parameter SETTLE_CYC  = `SETTLE_CYC
) (
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // User command port
    input  wire        req_valid,
    output wire        req_ready,
    input  wire [2:0]  req_op,
    input  wire [19:0] req_addr,
    input  wire [7:0]  req_data,
    output reg         rsp_valid_ff,
    output reg  [7:0]  rsp_data_ff,
    output reg         rsp_error_ff,
    // Flash pins
    output wire [19:0] flash_addr,
    output wire        chip_sel_n,
    output wire        out_en_n,
    output wire        wr_strobe_n,
    output wire [7:0]  data_pins_o,
    output wire        data_pins_oe,
    input  wire [7:0]  data_pins_i
);
    // ============================================================
    // States
    localparam ST_IDLE   = 3'd0;
    localparam ST_WRITE  = 3'd1;
    localparam ST_READ   = 3'd2;
    localparam ST_POLL   = 3'd3;
    localparam ST_SETTLE = 3'd4;
    localparam ST_FINAL  = 3'd5;
    localparam ST_RESP   = 3'd6;

    reg  [2:0]  state_ff;
    reg  [2:0]  nxt_state;
    reg  [2:0]  op_ff;
    reg  [19:0] addr_ff;
    reg  [7:0]  data_ff;
    reg  [2:0]  step_ff;
    reg  [2:0]  nxt_step;
    reg  [31:0] timer_ff;
    reg  [7:0]  prev_ff;
    reg         have_prev_ff;
    reg         cyc_start;
    reg         cyc_write;
    reg  [19:0] cyc_addr;
    reg  [7:0]  cyc_data;
    reg  [2:0]  seq_len;
    wire        cyc_done;
    wire [7:0]  cyc_rdata;

    assign req_ready = (state_ff == ST_IDLE);

    bus_cycle bus_cycle_inst (
        .mclk            (mclk),
        .rst_n           (rst_n),
        .start           (cyc_start),
        .is_write        (cyc_write),
        .addr            (cyc_addr),
        .wdata           (cyc_data),
        .done            (cyc_done),
        .rdata_ff        (cyc_rdata),
        .flash_addr_ff   (flash_addr),
        .chip_sel_n_ff   (chip_sel_n),
        .out_en_n_ff     (out_en_n),
        .wr_strobe_n_ff  (wr_strobe_n),
        .data_pins_o_ff  (data_pins_o),
        .data_pins_oe_ff (data_pins_oe),
        .data_pins_i     (data_pins_i)
    );

    // ============================================================
    // Command sequence table
    always @* begin
        case (op_ff)
            `OP_PROGRAM:     seq_len = 3'd4;
            `OP_SECTOR_ERASE,
            `OP_BLOCK_ERASE,
            `OP_CHIP_ERASE:  seq_len = 3'd6;
            `OP_EXIT:        seq_len = 3'd1;
            default:         seq_len = 3'd3;
        endcase
    end

    always @* begin
        cyc_addr = `UNLOCK_ADDR1;
        cyc_data = `UNLOCK_DATA1;
        case (step_ff)
            3'd0: begin
                if (op_ff == `OP_EXIT) begin
                    cyc_data = `CMD_EXIT;
                end
            end
            3'd1, 3'd4: begin
                cyc_addr = `UNLOCK_ADDR2;
                cyc_data = `UNLOCK_DATA2;
            end
            3'd2: begin
                case (op_ff)
                    `OP_PROGRAM:     cyc_data = `CMD_PROGRAM;
                    `OP_ID_ENTRY:    cyc_data = `CMD_ID_ENTRY;
                    `OP_QUERY_ENTRY: cyc_data = `CMD_QUERY_ENTRY;
                    default:         cyc_data = `CMD_ERASE_SETUP;
                endcase
            end
            3'd3: begin
                if (op_ff == `OP_PROGRAM) begin
                    cyc_addr = addr_ff;
                    cyc_data = data_ff;
                end
            end
            3'd5: begin
                case (op_ff)
                    `OP_SECTOR_ERASE: begin
                        // Low bits cleared: sector picked by top bits
                        cyc_addr = {addr_ff[19:`SECTOR_LSB], 12'h000};
                        cyc_data = `CMD_SECTOR_ERASE;
                    end
                    `OP_BLOCK_ERASE: begin
                        cyc_addr = {addr_ff[19:`BLOCK_LSB], 16'h0000};
                        cyc_data = `CMD_BLOCK_ERASE;
                    end
                    default: cyc_data = `CMD_CHIP_ERASE;
                endcase
            end
            default: cyc_data = `UNLOCK_DATA1;
        endcase
        if (state_ff == ST_READ || state_ff == ST_POLL ||
            state_ff == ST_FINAL) begin
            cyc_addr = addr_ff;
        end
    end

    // ============================================================
    // Controller
    wire is_alter = (op_ff == `OP_PROGRAM) || (op_ff == `OP_SECTOR_ERASE) ||
                    (op_ff == `OP_BLOCK_ERASE) || (op_ff == `OP_CHIP_ERASE);
    // Expected poll bit when done: true data for program, one for erase
    wire poll_target = (op_ff == `OP_PROGRAM) ? data_ff[`POLL_BIT] : 1'b1;
    // Done needs both indications: stable busy bit and true poll bit
    wire poll_done   = have_prev_ff &&
                       (cyc_rdata[`BUSY_BIT] == prev_ff[`BUSY_BIT]) &&
                       (cyc_rdata[`POLL_BIT] == poll_target);

    always @* begin
        nxt_state = state_ff;
        nxt_step  = step_ff;
        cyc_start = 1'b0;
        cyc_write = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (req_valid) begin
                    nxt_step  = 3'd0;
                    nxt_state = (req_op == `OP_READ) ? ST_READ : ST_WRITE;
                end
            end
            ST_WRITE: begin
                cyc_start = 1'b1;
                cyc_write = 1'b1;
                if (cyc_done) begin
                    if (step_ff == seq_len - 3'd1) begin
                        // Polling starts after the last strobe rises
                        nxt_state = is_alter ? ST_POLL : ST_RESP;
                    end else begin
                        nxt_step = step_ff + 3'd1;
                    end
                end
            end
            ST_READ: begin
                cyc_start = 1'b1;
                if (cyc_done) begin
                    nxt_state = ST_RESP;
                end
            end
            ST_POLL: begin
                cyc_start = 1'b1;
                if (cyc_done && poll_done) begin
                    nxt_state = ST_SETTLE;
                end else if (cyc_done && timer_ff >= TIMEOUT_CYC) begin
                    nxt_state = ST_RESP;
                end
            end
            ST_SETTLE: begin
                if (timer_ff >= SETTLE_CYC) begin
                    nxt_state = ST_FINAL;
                end
            end
            ST_FINAL: begin
                cyc_start = 1'b1;
                if (cyc_done) begin
                    nxt_state = ST_RESP;
                end
            end
            ST_RESP:  nxt_state = ST_IDLE;
            default:  nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff     <= ST_IDLE;
            step_ff      <= 3'd0;
            op_ff        <= `OP_READ;
            addr_ff      <= 20'h0_0000;
            data_ff      <= 8'h00;
            timer_ff     <= 32'h0000_0000;
            prev_ff      <= 8'h00;
            have_prev_ff <= 1'b0;
            rsp_valid_ff <= 1'b0;
            rsp_data_ff  <= 8'h00;
            rsp_error_ff <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            step_ff      <= nxt_step;
            rsp_valid_ff <= 1'b0;
            if (state_ff == ST_IDLE && req_valid) begin
                op_ff        <= req_op;
                addr_ff      <= req_addr;
                data_ff      <= req_data;
                rsp_error_ff <= 1'b0;
            end
            if (state_ff != nxt_state) begin
                timer_ff     <= 32'h0000_0000;
                have_prev_ff <= 1'b0;
            end else begin
                timer_ff <= timer_ff + 32'h0000_0001;
            end
            if (state_ff == ST_POLL && cyc_done) begin
                prev_ff      <= cyc_rdata;
                have_prev_ff <= 1'b1;
            end
            if (state_ff == ST_POLL && nxt_state == ST_RESP) begin
                rsp_error_ff <= 1'b1;
            end
            if (state_ff == ST_RESP) begin
                rsp_valid_ff <= 1'b1;
            end
            if ((state_ff == ST_READ || state_ff == ST_FINAL) && cyc_done) begin
                rsp_data_ff <= cyc_rdata;
            end
        end
    end
endmodule // flash_host

/* hw/flash_host_defines.vh */
// Constants for the parallel flash host controller.
// Assumes a 100 MHz mclk; included by its bare name.
`ifndef FLASH_HOST_DEFINES_VH
`define FLASH_HOST_DEFINES_VH

// ============================================================
// Command addresses and codes
`define UNLOCK_ADDR1      20'h0_5555
`define UNLOCK_ADDR2      20'h0_2AAA
`define UNLOCK_DATA1      8'hAA
`define UNLOCK_DATA2      8'h55
`define CMD_PROGRAM       8'hA0
`define CMD_ERASE_SETUP   8'h80
`define CMD_SECTOR_ERASE  8'h30
`define CMD_BLOCK_ERASE   8'h50
`define CMD_CHIP_ERASE    8'h10
`define CMD_ID_ENTRY      8'h90
`define CMD_QUERY_ENTRY   8'h98
`define CMD_EXIT          8'hF0
`define ID_MAKER_ADDR     20'h0_0000
`define ID_PART_ADDR      20'h0_0001

// ============================================================
// Operation codes on the user port
`define OP_READ           3'h0
`define OP_PROGRAM        3'h1
`define OP_SECTOR_ERASE   3'h2
`define OP_BLOCK_ERASE    3'h3
`define OP_CHIP_ERASE     3'h4
`define OP_ID_ENTRY       3'h5
`define OP_QUERY_ENTRY    3'h6
`define OP_EXIT           3'h7

// ============================================================
// Field positions
`define POLL_BIT          7
`define BUSY_BIT          6
`define SECTOR_LSB        12
`define BLOCK_LSB         16

// ============================================================
// Timing, ns and derived cycles at 10 ns
`define CLK_PERIOD_NS     10
`define STROBE_LOW_NS     40
`define STROBE_LOW_CYC    ((`STROBE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_NS         1000
`define SETTLE_CYC        ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_NS           100
`define READ_CYC          ((`READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMEOUT_DEF       32'd20_000_000

`endif

/* hw/bus_cycle.v */
// One asynchronous flash bus cycle: read or write strobe timing.
// Assumes the flash pins are wired straight to its ports.
`timescale 1ns/10ps
`include "flash_host_defines.vh"

module bus_cycle #(
    parameter LOW_CYC  = `STROBE_LOW_CYC,
    parameter READ_CYC = `READ_CYC
) (
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // Request
    input  wire        start,
    input  wire        is_write,
    input  wire [19:0] addr,
    input  wire [7:0]  wdata,
    output wire        done,
    output reg  [7:0]  rdata_ff,
    // Flash pins
    output reg  [19:0] flash_addr_ff,
    output reg         chip_sel_n_ff,
    output reg         out_en_n_ff,
    output reg         wr_strobe_n_ff,
    output reg  [7:0]  data_pins_o_ff,
    output reg         data_pins_oe_ff,
    input  wire [7:0]  data_pins_i
);
    reg [7:0] cnt_ff;
    reg       busy_ff;
    reg       last_ff;
    // ============================================================
    // Strobe sequencer
    assign done = last_ff;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff          <= 8'h00;
            busy_ff         <= 1'b0;
            last_ff         <= 1'b0;
            rdata_ff        <= 8'h00;
            flash_addr_ff   <= 20'h0_0000;
            chip_sel_n_ff   <= 1'b1;
            out_en_n_ff     <= 1'b1;
            wr_strobe_n_ff  <= 1'b1;
            data_pins_o_ff  <= 8'h00;
            data_pins_oe_ff <= 1'b0;
        end else begin
            last_ff <= 1'b0;
            // No start on the done cycle: the old step is still shown
            if (start && !busy_ff && !last_ff) begin
                busy_ff         <= 1'b1;
                flash_addr_ff   <= addr;
                chip_sel_n_ff   <= 1'b0;
                // Output enable stays high on writes so the write is not inhibited
                out_en_n_ff     <= is_write;
                wr_strobe_n_ff  <= !is_write;
                data_pins_o_ff  <= wdata;
                data_pins_oe_ff <= is_write;
                cnt_ff <= is_write ? LOW_CYC[7:0] : READ_CYC[7:0];
            end else if (busy_ff) begin
                if (cnt_ff > 8'h01) begin
                    cnt_ff <= cnt_ff - 8'h01;
                end else begin
                    // Strobes rise while data still driven: hold time met
                    busy_ff        <= 1'b0;
                    last_ff        <= 1'b1;
                    chip_sel_n_ff  <= 1'b1;
                    out_en_n_ff    <= 1'b1;
                    wr_strobe_n_ff <= 1'b1;
                    if (wr_strobe_n_ff) begin
                        rdata_ff <= data_pins_i;
                    end
                end
            end else begin
                data_pins_oe_ff <= 1'b0;
            end
        end
    end
endmodule // bus_cycle

/* dv/flash_host_chk.sv */
// Port checker for the flash host controller.
// Assumes it is bound onto every flash_host instance.
`timescale 1ns/10ps
module flash_host_chk (
    // Clock and reset
    input wire        mclk,
    input wire        rst_n,
    // Watched ports
    input wire        rsp_valid_ff,
    input wire [19:0] flash_addr,
    input wire        chip_sel_n,
    input wire        out_en_n,
    input wire        wr_strobe_n,
    input wire [7:0]  data_pins_o,
    input wire        data_pins_oe
);
    // ====
    // Pin and response rules
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    write_inhibit_a:
    assert property (!out_en_n |-> wr_strobe_n)
        else $error("read and write strobes low together");
    bus_float_a:
    assert property (data_pins_oe |-> out_en_n)
        else $error("host drives while flash may drive");
    strobe_select_a:
    assert property (!wr_strobe_n |-> !chip_sel_n)
        else $error("write strobe without chip select");
    strobe_width_a:
    assert property ($fell(wr_strobe_n) |-> !wr_strobe_n [*4] ##1 wr_strobe_n)
        else $error("write strobe width wrong");
    latch_hold_a:
    assert property (!wr_strobe_n && !$past(wr_strobe_n)
        |-> $stable(flash_addr) && $stable(data_pins_o))
        else $error("address or data moved under strobe");
    cmd_addr_a:
    assert property ($rose(wr_strobe_n) && data_pins_o inside
        {8'hA0, 8'h80, 8'h90, 8'h98, 8'h10} |-> flash_addr[14:0] == 15'h5555)
        else $error("command byte at wrong address");
    sector_addr_a:
    assert property ($rose(wr_strobe_n) && data_pins_o == 8'h30
        |-> flash_addr[11:0] == 12'h000)
        else $error("sector address has low bits set");
    block_addr_a:
    assert property ($rose(wr_strobe_n) && data_pins_o == 8'h50
        |-> flash_addr[15:0] == 16'h0000)
        else $error("block address has low bits set");
    rsp_pulse_a:
    assert property (rsp_valid_ff |=> !rsp_valid_ff)
        else $error("response longer than one cycle");
endmodule // flash_host_chk

bind flash_host flash_host_chk flash_host_chk_inst (
    .mclk(mclk), .rst_n(rst_n), .rsp_valid_ff(rsp_valid_ff),
    .flash_addr(flash_addr), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n),
    .data_pins_o(data_pins_o), .data_pins_oe(data_pins_oe));

/* dv/flash_model.sv */
// Behavioural parallel flash facing the host pins.
// Assumes pins settle between mclk edges; no reset, as the part has none.
`timescale 1ns/10ps
module flash_model #(
    parameter [7:0] MAKER    = 8'h3A, // Arbitrary value
    parameter [7:0] PART     = 8'h6C, // Arbitrary value
    parameter       BUSY_CYC = 40
) (
    // Clock and fault control
    input  wire        mclk,
    input  wire        stuck,
    // Flash pins
    input  wire [19:0] flash_addr,
    input  wire        chip_sel_n,
    input  wire        out_en_n,
    input  wire        wr_strobe_n,
    input  wire [7:0]  data_pins_o,
    input  wire        data_pins_oe,
    output wire [7:0]  data_pins_i
);
    // ====
    // Array held inverted so zeroed storage reads as erased
    bit   [7:0]  mem_n [0:1048575];
    logic [7:0]  rd = 0, last = 0, wd = 0, d_q = 0;
    logic [19:0] a_q = 0;
    logic [2:0]  step = 0;
    logic [1:0]  mode = 0;
    logic        er = 0, tog = 0, we_q = 1, oe_q = 1, cs_q = 1;
    int          busy = 0;

    // Released bus shows the inverse of its last value
    assign data_pins_i = data_pins_oe ? data_pins_o :
        (!chip_sel_n && !out_en_n) ? rd : ~last;

    task automatic take(input [19:0] wa, input [7:0] d);
        logic [14:0] c;
        logic [2:0]  nxt;
        c = wa[14:0];
        nxt = 0;
        if (step == 0 || step == 4)
            nxt = (c == 15'h5555 && d == 8'hAA) ? step + 1 : 0;
        else if (step == 1 || step == 5)
            nxt = (c == 15'h2AAA && d == 8'h55) ? step + 1 : 0;
        else if (step == 2 && c == 15'h5555) begin
            nxt = (d == 8'hA0) ? 3 : (d == 8'h80) ? 4 : 0;
            if (d == 8'h90 || d == 8'h98 || d == 8'hF0)
                mode <= (d == 8'h90) ? 1 : (d == 8'h98) ? 2 : 0;
        end else if (step == 3) begin
            // Programming only clears bits
            mem_n[wa] = mem_n[wa] | ~d;
            wd <= d;
            er <= 0;
            busy <= BUSY_CYC;
        end else if (step == 6 && (d == 8'h30 || d == 8'h50 ||
                     (d == 8'h10 && c == 15'h5555))) begin
            er <= 1;
            busy <= 2 * BUSY_CYC;
            for (int i = 0; i < 1048576; i++)
                if (d == 8'h10 || (d == 8'h30 ? i[19:12] == wa[19:12] :
                                   i[19:16] == wa[19:16]))
                    mem_n[i] = 0;
        end
        if (step == 0 && d == 8'hF0)
            mode <= 0;
        step <= nxt;
    endtask

    always @(posedge mclk) begin
        if (busy > 0 && !stuck)
            busy <= busy - 1;
        if (busy > 0)
            rd <= {er ? 1'b0 : ~wd[7], tog, 6'h00};
        else if (mode != 0)
            rd <= (mode == 1) ? (flash_addr[0] ? PART : MAKER) :
                  (flash_addr == 20'h0_0010) ? 8'h51 : 8'h00;
        else
            rd <= ~mem_n[flash_addr];
        if (!chip_sel_n && !out_en_n) begin
            last <= data_pins_i;
            if (oe_q && busy > 0)
                tog <= ~tog;
        end
        // Sampling drops strobes shorter than a clock period
        if (!we_q && wr_strobe_n && !cs_q && oe_q && busy == 0)
            take(a_q, d_q);
        we_q <= wr_strobe_n;
        oe_q <= out_en_n;
        cs_q <= chip_sel_n;
        a_q <= flash_addr;
        d_q <= data_pins_o;
    end
endmodule // flash_model

/* dv/flash_host_bench.sv */
// Self-checking bench: flash host against a behavioural flash.
// Assumes the checker and flash model are compiled first.
`timescale 1ns/10ps
module flash_host_bench;
    localparam [7:0] MAKER = 8'h3A; // Arbitrary value
    localparam [7:0] PART  = 8'h6C; // Arbitrary value
    logic        mclk, rst_n, req_valid, stuck, err;
    logic [2:0]  req_op;
    logic [19:0] req_addr;
    logic [7:0]  req_data, got;
    wire         req_ready, rsp_valid_ff, rsp_error_ff, data_pins_oe;
    wire         chip_sel_n, out_en_n, wr_strobe_n;
    wire  [7:0]  rsp_data_ff, data_pins_o, data_pins_i;
    wire  [19:0] flash_addr;
    int          miscompares = 0, num_checks = 0, k;
    logic [30:0] rows [19];

    flash_host #(.TIMEOUT_CYC(2000), .SETTLE_CYC(5)) flash_host_inst (
        .mclk(mclk), .rst_n(rst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
        .req_data(req_data), .rsp_valid_ff(rsp_valid_ff),
        .rsp_data_ff(rsp_data_ff), .rsp_error_ff(rsp_error_ff),
        .flash_addr(flash_addr), .chip_sel_n(chip_sel_n),
        .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n),
        .data_pins_o(data_pins_o), .data_pins_oe(data_pins_oe),
        .data_pins_i(data_pins_i));
    flash_model #(.MAKER(MAKER), .PART(PART)) flash_model_inst (
        .mclk(mclk), .stuck(stuck), .flash_addr(flash_addr),
        .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
        .wr_strobe_n(wr_strobe_n), .data_pins_o(data_pins_o),
        .data_pins_oe(data_pins_oe), .data_pins_i(data_pins_i));

    // ====
    // Shared tasks
    task automatic check(input [7:0] seen, input [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Request held until taken; bounded waits end the run on a hang
    task automatic run(input [2:0] op, input [19:0] a, input [7:0] d);
        int n;
        req_op = op;
        req_addr = a;
        req_data = d;
        req_valid = 1;
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 50) begin
            miscompares++;
            report_and_stop;
        end
        @(negedge mclk);
        req_valid = 0;
        n = 0;
        while (rsp_valid_ff !== 1'b1 && n < 5000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 5000) begin
            miscompares++;
            report_and_stop;
        end
        got = rsp_data_ff;
        err = rsp_error_ff;
        @(negedge mclk);
    endtask

    initial begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end

    // ====
    // Main sequence
    initial begin
        rst_n = 0;
        req_valid = 0;
        req_op = 0;
        req_addr = 0;
        req_data = 0;
        stuck = 0;
        got = 0;
        err = 0;
        rows = '{{3'h1, 20'h0_0010, 8'h3C}, {3'h1, 20'h0_1000, 8'h99},
                 {3'h1, 20'h0_0050, 8'hC3}, {3'h5, 20'h0_0000, 8'h00},
                 {3'h0, 20'h0_0000, MAKER}, {3'h0, 20'h0_0001, PART},
                 {3'h7, 20'h0_0000, 8'h00}, {3'h0, 20'h0_0010, 8'h3C},
                 {3'h6, 20'h0_0000, 8'h00}, {3'h0, 20'h0_0010, 8'h51},
                 {3'h0, 20'h0_0010, 8'h51}, {3'h7, 20'h0_0000, 8'h00},
                 {3'h2, 20'h0_0ABC, 8'hFF}, {3'h0, 20'h0_0010, 8'hFF},
                 {3'h0, 20'h0_1000, 8'h99}, {3'h1, 20'h2_1000, 8'h5A},
                 {3'h3, 20'h2_F123, 8'hFF}, {3'h0, 20'h2_1000, 8'hFF},
                 {3'h4, 20'h0_1000, 8'hFF}};
        repeat (6) @(negedge mclk);
        check({4'h0, chip_sel_n, out_en_n, wr_strobe_n, data_pins_oe}, 8'h0E);
        rst_n = 1;
        @(negedge mclk);
        for (k = 0; k < 19; k++) begin
            run(rows[k][30:28], rows[k][27:8], rows[k][7:0]);
            if (rows[k][30:28] < 3'h5)
                check(got, rows[k][7:0]);
            check({7'h00, err}, 8'h00);
        end
        // Flash never finishes: host must give up with an error
        stuck = 1;
        run(3'h1, 20'h0_0040, 8'h4B);
        check({7'h00, err}, 8'h01);
        stuck = 0;
        got = 0;
        k = 0;
        while (got !== 8'h4B && k < 10) begin
            run(3'h0, 20'h0_0040, 8'h00);
            k++;
        end
        check(got, 8'h4B);
        // Reset in mid-sequence, then recover with the exit command
        req_op = 3'h1;
        req_addr = 20'h0_0080;
        req_data = 8'h22;
        req_valid = 1;
        repeat (12) @(negedge mclk);
        rst_n = 0;
        req_valid = 0;
        @(negedge mclk);
        check({4'h0, chip_sel_n, out_en_n, wr_strobe_n, data_pins_oe}, 8'h0E);
        rst_n = 1;
        @(negedge mclk);
        run(3'h7, 20'h0_0000, 8'h00);
        run(3'h1, 20'h0_0080, 8'h22);
        check(got, 8'h22);
        report_and_stop;
    end
endmodule // flash_host_bench
